// ---- dwdt_map.vh ----
`ifndef DWDT_MAP_VH
`define DWDT_MAP_VH
// register byte offsets
`define DWDT_CFG1_OFF      12'h000
`define DWDT_CFG4_OFF      12'h004
`define DWDT_RESET_CONTROL_REG_OFF      12'h008
`define DWDT_CMD_OFF       12'h00c
`define DWDT_STAT_OFF      12'h010
// config word one fields
`define DWDT_PS_LSB        0
`define DWDT_PS_MSB        3
`define DWDT_PSA_BIT       4
`define DWDT_HWEN_BIT      5
`define DWDT_WINDOW_DISABLE_CFG_BIT    6
// config word four fields
`define DWDT_DSPS_LSB      0
`define DWDT_DSPS_MSB      3
`define DWDT_DSOSC_BIT     4
`define DWDT_DSEN_BIT      7
// reset control fields
`define DWDT_IDLE_BIT      2
`define DWDT_SLEEP_BIT     3
`define DWDT_TIMEOUT_FLAG_BIT      4
`define DWDT_SWEN_BIT      5
`define DWDT_DSWAKE_BIT    6
// command bits (write one to issue)
`define DWDT_CMD_CLR       0
`define DWDT_CMD_SLEEP     1
`define DWDT_CMD_IDLE      2
`define DWDT_CMD_WAKE      3
`define DWDT_CMD_CLKSW     4
`define DWDT_CMD_DSLEEP    5
// reset values (unprogrammed config reads ones)
`define DWDT_CFG1_RST      8'hff
`define DWDT_CFG4_RST      8'hff
// timing
`define DWDT_LOW_POWER_RC_OSC_HZ       31000
`define DWDT_PRE_SHORT     8'h20
`define DWDT_PRE_LONG      8'h80
`define DWDT_DS_PRE        8'h20
`endif

// ---- dwdt_tick_div.v ----
`timescale 1ns/1ps
// divides one-cycle input ticks, emits a one-cycle pulse per terminal count
module dwdt_tick_div #(
  parameter W = 8
) (
  input  wire         hclk,
  input  wire         hresetn,
  input  wire         clr,
  input  wire         tick_in,
  input  wire [W-1:0] term,
  output reg          tick_out
);
  reg [W-1:0] cnt_r;

  // counter restarts on clear, pulses at term-1
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r    <= {W{1'b0}};
      tick_out <= 1'b0;
    end else if (clr) begin
      cnt_r    <= {W{1'b0}};
      tick_out <= 1'b0;
    end else if (tick_in) begin
      if (cnt_r >= term - {{(W-1){1'b0}}, 1'b1}) begin
        cnt_r    <= {W{1'b0}};
        tick_out <= 1'b1;
      end else begin
        cnt_r    <= cnt_r + {{(W-1){1'b0}}, 1'b1};
        tick_out <= 1'b0;
      end
    end else begin
      tick_out <= 1'b0;
    end
  end
endmodule // dwdt_tick_div

// ---- dwdt_top.v ----
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "dwdt_map.vh"
module dwdt_top #(
  parameter LOW_POWER_RC_OSC_DIV = 3226  // hclk cycles per oscillator tick (100 MHz / 31 kHz)
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        secondary_osc_tick,
  input  wire        fscm_switch,
  output reg         low_power_rc_osc_en,
  output reg         secondary_osc_en,
  output reg         wdt_reset,
  output reg         wake_req
);
  // prescale terms sized to the divider width
  localparam [7:0] PRE_SHORT_T = `DWDT_PRE_SHORT;
  localparam [7:0] PRE_LONG_T  = `DWDT_PRE_LONG;
  localparam [7:0] DS_PRE_T    = `DWDT_DS_PRE;

  // register state
  reg  [7:0]  cfg1_r;
  reg  [7:0]  cfg4_r;
  reg         idle_flag_r;
  reg         sleep_flag_r;
  reg         timeout_flag_r;
  reg         swen_r;
  reg         dswake_r;
  reg         asleep_r;
  reg         deep_r;
  // bus address phase capture
  reg         wr_pend_r;
  reg         rd_pend_r;
  reg  [11:0] addr_r;
  // time base
  reg  [11:0] low_power_rc_osc_cnt_r;
  reg         low_power_rc_osc_tick_r;
  reg  [15:0] post_cnt_r;
  reg  [31:0] ds_cnt_r;

  wire        run_en;
  wire        win_mode;
  wire [15:0] post_term;
  wire [31:0] ds_term;
  wire [7:0]  pre_term;
  wire        pre_tick;
  wire        ds_src_tick;
  wire        ds_pre_tick;
  wire        ds_en;
  wire        cmd_wr;
  wire        cmd_clr;
  wire        cmd_slp;
  wire        cmd_idl;
  wire        cmd_wak;
  wire        cmd_sw;
  wire        cmd_ds;
  wire        wd_clear;
  wire        timeout;
  wire        early_clr;
  wire        dev_rst;
  wire        ds_timeout;
  wire        rd_take;
  wire        wr_cfg1;
  wire        wr_cfg4;
  wire        wr_reset_control_reg;

  // address match on the low twelve bits
  function addr_hit;
    input [11:0] a;
    input [11:0] off;
    begin
      addr_hit = (a == off);
    end
  endfunction

  // power of two helpers
  function [15:0] pow2_16;
    input [3:0] e;
    begin
      pow2_16 = 16'h0001 << e;
    end
  endfunction

  function [31:0] pow4x2;
    input [3:0] e;
    begin
      pow4x2 = 32'h0000_0002 << {e, 1'b0};
    end
  endfunction

  // enable selection
  assign run_en    = cfg1_r[`DWDT_HWEN_BIT] | swen_r;
  assign win_mode  = ~cfg1_r[`DWDT_WINDOW_DISABLE_CFG_BIT];
  assign pre_term  = cfg1_r[`DWDT_PSA_BIT] ? PRE_LONG_T
                                          : PRE_SHORT_T;
  assign post_term = pow2_16(cfg1_r[`DWDT_PS_MSB:`DWDT_PS_LSB]);
  assign ds_en     = cfg4_r[`DWDT_DSEN_BIT];
  assign ds_term   = pow4x2(cfg4_r[`DWDT_DSPS_MSB:`DWDT_DSPS_LSB]);
  assign ds_src_tick = cfg4_r[`DWDT_DSOSC_BIT] ? low_power_rc_osc_tick_r : secondary_osc_tick;

  // register write and read decode
  assign wr_cfg1 = wr_pend_r && addr_hit(addr_r, `DWDT_CFG1_OFF);
  assign wr_cfg4 = wr_pend_r && addr_hit(addr_r, `DWDT_CFG4_OFF);
  assign wr_reset_control_reg = wr_pend_r && addr_hit(addr_r, `DWDT_RESET_CONTROL_REG_OFF);
  assign rd_take = hready && hsel && htrans[1] && !hwrite;

  // command decode from bus write; clock switch also from fscm_switch
  assign cmd_wr  = wr_pend_r && addr_hit(addr_r, `DWDT_CMD_OFF);
  assign cmd_clr = cmd_wr && hwdata[`DWDT_CMD_CLR];
  assign cmd_slp = cmd_wr && hwdata[`DWDT_CMD_SLEEP];
  assign cmd_idl = cmd_wr && hwdata[`DWDT_CMD_IDLE];
  assign cmd_wak = cmd_wr && hwdata[`DWDT_CMD_WAKE];
  assign cmd_sw  = (cmd_wr && hwdata[`DWDT_CMD_CLKSW]) || fscm_switch;
  assign cmd_ds  = cmd_wr && hwdata[`DWDT_CMD_DSLEEP];

  // window: clear legal only in last quarter of period
  assign early_clr = cmd_clr && run_en && win_mode && !asleep_r
                     && ({post_cnt_r, 2'b00} < {post_term, 2'b00} - {2'b00, post_term});
  assign timeout   = run_en && pre_tick && (post_cnt_r >= post_term - 16'h0001);
  assign dev_rst   = (timeout && !asleep_r) || early_clr;
  // the run-mode prescaler and postscaler restart on these events
  assign wd_clear  = cmd_clr || cmd_slp || cmd_idl || cmd_wak || cmd_sw
                     || !run_en || timeout || early_clr;
  assign ds_timeout = ds_en && deep_r && ds_pre_tick && (ds_cnt_r >= ds_term - 32'h1);

  // oscillator tick generator, runs while a watchdog needs it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_power_rc_osc_cnt_r  <= 12'h000;
      low_power_rc_osc_tick_r <= 1'b0;
    end else if (!(run_en || (ds_en && cfg4_r[`DWDT_DSOSC_BIT]))) begin
      low_power_rc_osc_cnt_r  <= 12'h000;
      low_power_rc_osc_tick_r <= 1'b0;
    end else if (low_power_rc_osc_cnt_r == LOW_POWER_RC_OSC_DIV[11:0] - 12'h001) begin
      low_power_rc_osc_cnt_r  <= 12'h000;
      low_power_rc_osc_tick_r <= 1'b1;
    end else begin
      low_power_rc_osc_cnt_r  <= low_power_rc_osc_cnt_r + 12'h001;
      low_power_rc_osc_tick_r <= 1'b0;
    end
  end

  // run-mode prescaler
  dwdt_tick_div #(.W(8)) u_pre (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .clr      (wd_clear),
    .tick_in  (low_power_rc_osc_tick_r),
    .term     (pre_term),
    .tick_out (pre_tick)
  );

  // deep sleep fixed prescaler
  dwdt_tick_div #(.W(8)) u_ds_pre (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .clr      (!(ds_en && deep_r)),
    .tick_in  (ds_src_tick),
    .term     (DS_PRE_T),
    .tick_out (ds_pre_tick)
  );

  // postscalers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      post_cnt_r <= 16'h0000;
      ds_cnt_r   <= 32'h0000_0000;
    end else begin
      if (wd_clear)
        post_cnt_r <= 16'h0000;
      else if (pre_tick)
        post_cnt_r <= post_cnt_r + 16'h0001;
      // deep sleep counter only runs while in deep sleep
      if (!(ds_en && deep_r) || ds_timeout)
        ds_cnt_r <= 32'h0000_0000;
      else if (ds_pre_tick)
        ds_cnt_r <= ds_cnt_r + 32'h0000_0001;
    end
  end

  // power state, flags and outputs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      asleep_r     <= 1'b0;
      deep_r       <= 1'b0;
      idle_flag_r  <= 1'b0;
      sleep_flag_r <= 1'b0;
      timeout_flag_r       <= 1'b0;
      swen_r       <= 1'b0;
      dswake_r     <= 1'b0;
      wdt_reset    <= 1'b0;
      wake_req     <= 1'b0;
      low_power_rc_osc_en      <= 1'b0;
      secondary_osc_en      <= 1'b0;
    end else begin
      // pulses and oscillator requests
      wdt_reset <= dev_rst;
      wake_req  <= (timeout && asleep_r) || ds_timeout;
      low_power_rc_osc_en   <= run_en || (ds_en && cfg4_r[`DWDT_DSOSC_BIT]);
      secondary_osc_en   <= ds_en && !cfg4_r[`DWDT_DSOSC_BIT];
      if (dev_rst) begin
        swen_r   <= 1'b0;
        asleep_r <= 1'b0;
      end else if (timeout && asleep_r)
        asleep_r <= 1'b0;
      else if (cmd_slp || cmd_idl || cmd_ds)
        asleep_r <= 1'b1;
      else if (cmd_wak)
        asleep_r <= 1'b0;
      if (ds_timeout || cmd_wak || dev_rst)
        deep_r <= 1'b0;
      else if (cmd_ds)
        deep_r <= 1'b1;
      // register writes to the reset control word; hardware sets win
      if (wr_reset_control_reg) begin
        idle_flag_r  <= hwdata[`DWDT_IDLE_BIT] | cmd_idl;
        sleep_flag_r <= hwdata[`DWDT_SLEEP_BIT] | cmd_slp | cmd_ds;
        timeout_flag_r       <= hwdata[`DWDT_TIMEOUT_FLAG_BIT] | dev_rst;
        swen_r       <= hwdata[`DWDT_SWEN_BIT] & ~dev_rst;
        dswake_r     <= hwdata[`DWDT_DSWAKE_BIT] | ds_timeout;
      end else begin
        if (cmd_idl) idle_flag_r <= 1'b1;
        if (cmd_slp || cmd_ds) sleep_flag_r <= 1'b1;
        if (dev_rst) timeout_flag_r <= 1'b1;
        if (ds_timeout) dswake_r <= 1'b1;
      end
    end
  end

  // ahb-lite slave: address phase capture, zero wait states
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= 12'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      // capture the address phase of the next transfer
      if (hready) begin
        wr_pend_r <= hsel && htrans[1] && hwrite;
        rd_pend_r <= hsel && htrans[1] && !hwrite;
        addr_r    <= {haddr[11:2], 2'b00};
      end
    end
  end

  // config writes and read data
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg1_r <= `DWDT_CFG1_RST;
      cfg4_r <= `DWDT_CFG4_RST;
      hrdata <= 32'h0000_0000;
    end else begin
      if (wr_pend_r) begin
        if (wr_cfg1)
          cfg1_r <= hwdata[7:0];
        else if (wr_cfg4)
          cfg4_r <= hwdata[7:0];
      end
      if (rd_take) begin
        if (addr_hit(haddr[11:0], `DWDT_CFG1_OFF))
          hrdata <= {24'h000000, cfg1_r};
        else if (addr_hit(haddr[11:0], `DWDT_CFG4_OFF))
          hrdata <= {24'h000000, cfg4_r};
        else if (addr_hit(haddr[11:0], `DWDT_RESET_CONTROL_REG_OFF))
          hrdata <= {25'h0000000, dswake_r, swen_r, timeout_flag_r, sleep_flag_r,
                     idle_flag_r, 2'b00};
        else if (addr_hit(haddr[11:0], `DWDT_STAT_OFF))
          hrdata <= {post_cnt_r, 13'h0000, deep_r, asleep_r, run_en};
        else
          hrdata <= 32'h0000_0000;
      end
    end
  end
endmodule // dwdt_top

// ---- dwdt_asserts.sv ----
`timescale 1ns/1ps
module dwdt_asserts #(
  parameter LOW_POWER_RC_OSC_DIV = 3226
) (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [2:0]  hsize,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        secondary_osc_tick,
  input wire        fscm_switch,
  input wire        low_power_rc_osc_en,
  input wire        secondary_osc_en,
  input wire        wdt_reset,
  input wire        wake_req
);
  // read address phase taken this edge
  wire rd_take = hsel && hready && htrans[1] && !hwrite;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  ready_high_a: assert property (hreadyout) else $error("hreadyout low");
  resp_okay_a: assert property (!hresp) else $error("hresp not okay");
  reset_gap_a: assert property (wdt_reset |=> !wdt_reset [*8])
    else $error("watchdog reset too soon after last one");
  wake_pulse_a: assert property (wake_req |=> !wake_req) else $error("wake held");
  reset_osc_on_a: assert property (wdt_reset |-> $past(low_power_rc_osc_en))
    else $error("watchdog reset without rc oscillator");
  wake_or_reset_a: assert property (!(wake_req && wdt_reset))
    else $error("wake and reset together");
  rd_hold_a: assert property (!rd_take |=> $stable(hrdata)) else $error("hrdata moved");
  unmapped_zero_a: assert property (rd_take && haddr > 32'h10 && haddr < 32'h1000
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  cover property (wdt_reset);
  cover property (wake_req);
  cover property ($rose(secondary_osc_en));
endmodule // dwdt_asserts
bind dwdt_top dwdt_asserts #(.LOW_POWER_RC_OSC_DIV(LOW_POWER_RC_OSC_DIV)) u_dwdt_asserts (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .secondary_osc_tick(secondary_osc_tick), .fscm_switch(fscm_switch),
  .low_power_rc_osc_en(low_power_rc_osc_en), .secondary_osc_en(secondary_osc_en), .wdt_reset(wdt_reset), .wake_req(wake_req));

// ---- dwdt_top_test.sv ----
`timescale 1ns/1ps
`include "dwdt_map.vh"
module dwdt_top_test;
  localparam int DIV = 2;
  localparam int SDIV = 4;
  localparam int PS = `DWDT_PRE_SHORT * DIV;
  localparam logic [31:0] CFG1 = {20'h0, `DWDT_CFG1_OFF};
  localparam logic [31:0] CFG4 = {20'h0, `DWDT_CFG4_OFF};
  localparam logic [31:0] RESET_CONTROL_REG = {20'h0, `DWDT_RESET_CONTROL_REG_OFF};
  localparam logic [31:0] CMD = {20'h0, `DWDT_CMD_OFF};
  localparam logic [31:0] STAT = {20'h0, `DWDT_STAT_OFF};
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, secondary_osc_tick = 0, fscm_switch = 0;
  logic [31:0] haddr = 0, hwdata = 0, q;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  wire  [31:0] hrdata;
  wire         hready, hreadyout, hresp, low_power_rc_osc_en, secondary_osc_en, wdt_reset, wake_req;
  int          err_count, compares, rst_cnt, n, k, m, scnt;
  // addr, data, write, mask, expected
  logic [31:0] tbl [10][5] = '{'{CFG1, 0, 0, 32'hff, 32'hff}, '{CFG4, 0, 0, 32'hff, 32'hff},
    '{RESET_CONTROL_REG, 0, 0, 32'h7c, 0}, '{STAT, 0, 0, 32'h1, 32'h1}, '{32'h40, 32'h5a, 1, 32'hff, 0},
    '{CFG1, 32'h40, 1, 32'hff, 32'h40}, '{STAT, 0, 0, 32'h1, 0},
    '{RESET_CONTROL_REG, 32'h20, 1, 32'h20, 32'h20}, '{STAT, 0, 0, 32'h1, 32'h1}, '{RESET_CONTROL_REG, 0, 1, 32'h20, 0}};
  int          pcfg [3] = '{32'h60, 32'h62, 32'h70};
  int          pper [3] = '{PS, PS * 4, `DWDT_PRE_LONG * DIV};
  int          dcfg [3] = '{32'h80, 32'h90, 32'h00};
  int          dper [3] = '{`DWDT_DS_PRE * 2 * SDIV, `DWDT_DS_PRE * 2 * DIV, 0};
  dwdt_top #(.LOW_POWER_RC_OSC_DIV(DIV)) u_dwdt_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .secondary_osc_tick(secondary_osc_tick), .fscm_switch(fscm_switch), .low_power_rc_osc_en(low_power_rc_osc_en),
    .secondary_osc_en(secondary_osc_en), .wdt_reset(wdt_reset), .wake_req(wake_req));
  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  // secondary oscillator ticks and reset pulse count
  always @(posedge hclk) begin
    scnt <= (scnt == SDIV - 1) ? 0 : scnt + 1;
    secondary_osc_tick <= (scnt == 0);
    if (wdt_reset === 1'b1) rst_cnt <= rst_cnt + 1;
  end
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1, a, d);
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", s, e, g);
      err_count++;
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] msk, input logic [31:0] e,
                    input string s);
    xfer(0, a, 32'h0);
    chk(s, e, q & msk);
  endtask
  // cycles until wake (sel) or reset pulse, capped
  task automatic wait_pulse(input logic sel, input int lim);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (n < lim && (sel ? wake_req : wdt_reset) !== 1'b1);
  endtask
  task automatic wrap_up;
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard
  initial begin
    #200000;
    err_count++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge hclk);
    chk("wdt_reset in reset", 0, wdt_reset);
    hresetn <= 1;
    repeat (3) @(posedge hclk);
    chk("low_power_rc_osc_en", 1, low_power_rc_osc_en);
    for (k = 0; k < 10; k++) begin
      if (tbl[k][2][0]) wr(tbl[k][0], tbl[k][1]);
      rd(tbl[k][0], tbl[k][3], tbl[k][4], "register");
    end
    // periods under hardware enable, software bit off
    for (k = 0; k < 3; k++) begin
      wr(CFG1, pcfg[k]);
      wr(RESET_CONTROL_REG, 0);
      wr(CMD, 1);
      wait_pulse(0, 600);
      chk("period", 1, n >= pper[k] - 8 && n <= pper[k] + 8);
      rd(RESET_CONTROL_REG, 32'h10, 32'h10, "timeout flag");
      wait_pulse(0, 600);
      chk("rerun", 1, n >= pper[k] - 12 && n <= pper[k] + 8);
    end
    wr(CFG1, 32'h40);
    rd(RESET_CONTROL_REG, 32'h10, 32'h10, "sticky flag");
    wr(RESET_CONTROL_REG, 0);
    rd(RESET_CONTROL_REG, 32'h10, 0, "flag cleared");
    // sleep then idle: time-out wakes, flags stay
    for (k = 0; k < 2; k++) begin
      wr(RESET_CONTROL_REG, 32'h20);
      wr(CMD, 1);
      wr(CMD, k ? 32'h4 : 32'h2);
      m = rst_cnt;
      wait_pulse(1, 100);
      chk("wake", 1, n >= PS - 8 && n <= PS + 8 && rst_cnt == m);
      rd(RESET_CONTROL_REG, k ? 32'h4 : 32'h8, k ? 32'h4 : 32'h8, "power-save flag");
      wr(RESET_CONTROL_REG, 0);
    end
    // clock switch command, then fail-safe switch, restart the count
    for (k = 0; k < 2; k++) begin
      wr(RESET_CONTROL_REG, 32'h20);
      wr(CMD, 1);
      repeat (40) @(posedge hclk);
      if (k) fscm_switch <= 1;
      else wr(CMD, 32'h10);
      @(posedge hclk);
      fscm_switch <= 0;
      wait_pulse(0, 120);
      chk("restart", 1, n > 48 && n <= PS + 16);
    end
    // window: late clear accepted, early clear resets
    wr(CFG1, 32'h42);
    wr(RESET_CONTROL_REG, 32'h20);
    wr(CMD, 1);
    wr(CFG1, 32'h02);
    repeat (210) @(posedge hclk);
    m = rst_cnt;
    wr(CMD, 1);
    repeat (20) @(posedge hclk);
    chk("late clear", m, rst_cnt);
    wr(CMD, 1);
    wait_pulse(0, 8);
    chk("early clear", 1, n < 8);
    // deep sleep: secondary, rc, disabled
    for (k = 0; k < 3; k++) begin
      wr(CFG4, dcfg[k]);
      wr(CMD, 32'h20);
      repeat (2) @(posedge hclk);
      if (k < 2) chk("ds clock", 1, k ? low_power_rc_osc_en : secondary_osc_en);
      wait_pulse(1, 400);
      if (k < 2) chk("ds wake", 1, n >= dper[k] - 10 && n <= dper[k] + 8);
      else chk("ds off", 400, n);
    end
    wr(CMD, 32'h8);
    // reset in mid-run
    wr(CFG1, 32'h40);
    wr(RESET_CONTROL_REG, 32'h20);
    hresetn <= 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    rd(RESET_CONTROL_REG, 32'h20, 0, "sw enable after reset");
    rd(CFG1, 32'hff, 32'hff, "cfg1 after reset");
    wrap_up;
  end
endmodule // dwdt_top_test
